/* File: verilog/ipe_cfg.svh */
// Constants for the interrupt priority and extended enable block.
// Operation
// - Priority-select bit 6 gives the serial peripheral interface low (0) or high (1) priority.
// - Priority-select bit 5 gives timer 2 low (0) or high (1) priority.
// - Priority-select bit 3 gives timer 1 low (0) or high (1) priority.
// - The extended enable register answers at address 0xE6 on every page, read and write.
// - Reset clears the whole extended enable register, masking all its sources.
// - Extended enable bit 7 passes either timer 3 overflow flag or masks both.
// - Extended enable bit 6 passes either comparator 1 edge flag or masks both.
// - Extended enable bit 5 passes either comparator 0 edge flag or masks both.
// - Extended enable bit 4 passes or masks all counter array requests.
// - Extended enable bit 3 passes or masks the end-of-conversion flag.
// - Extended enable bit 2 passes or masks the window-comparison flag.
// - Extended enable bit 1 is unused, reads zero and ignores writes.
// - Extended enable bit 0 passes or masks all SMBus requests.
// - No request reaches the core while the global gate is clear.
`ifndef IPE_CFG_SVH
`define IPE_CFG_SVH
`define IPE_EIE_ADDR 8'hE6
`define IPE_IP_ADDR 8'hB9
`define IPE_EIE_RESET 8'h00
`define IPE_IP_RESET 8'h80
`define IPE_EIE_USED 8'hFD
`define IPE_IP_USED 8'h7F
`define IPE_IP_FIXED 8'h80
`define IPE_EIE_T3 7
`define IPE_EIE_CP1 6
`define IPE_EIE_CP0 5
`define IPE_EIE_PCA 4
`define IPE_EIE_ADC 3
`define IPE_EIE_WIN 2
`define IPE_EIE_UNUSED 1
`define IPE_EIE_SMB 0
`define IPE_IP_SPI 6
`define IPE_IP_T2 5
`define IPE_IP_UART 4
`define IPE_IP_T1 3
`define IPE_IP_EXT1 2
`define IPE_IP_T0 1
`define IPE_IP_EXT0 0
`define IPE_NUM_LEGACY 7
`define IPE_NUM_SRC 14
`define IPE_PCA_FLAGS 7
`endif

/* File: verilog/ipe_pkg.sv */
// Types shared by the interrupt priority and extended enable block.
`default_nettype none
package ipe_pkg;
  typedef logic [7:0] ipe_byte_t;
  typedef logic [13:0] ipe_src_vec_t;
endpackage : ipe_pkg
`default_nettype wire

/* File: verilog/ipe_regs_if.sv */
// Interface between the register file and the gating logic.
`timescale 1ns/10ps
`default_nettype none
interface ipe_regs_if;
  logic [7:0] addr;
  ipe_pkg::ipe_byte_t wdata;
  logic we;
  logic re;
  ipe_pkg::ipe_byte_t rdata;
  ipe_pkg::ipe_byte_t prio_q;
  ipe_pkg::ipe_byte_t enable_q;
  modport regs (input addr, input wdata, input we, input re,
                output rdata, output prio_q, output enable_q);
  modport user (output addr, output wdata, output we, output re,
                input rdata, input prio_q, input enable_q);
endinterface : ipe_regs_if
`default_nettype wire

/* File: verilog/ipe_sfr.sv */
// Register file holding the priority-select and extended enable registers.
`timescale 1ns/10ps
`default_nettype none
`include "ipe_cfg.svh"
module ipe_sfr #(
  parameter logic [7:0] PRIO_ADDR = `IPE_IP_ADDR
) (
  input wire logic clock,
  input wire logic srst,
  ipe_regs_if.regs bus
);
  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  ipe_pkg::ipe_byte_t prio_q;
  ipe_pkg::ipe_byte_t enable_q;
  ipe_pkg::ipe_byte_t rdata_q;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prio_q <= `IPE_IP_RESET;
    end
    else if (bus.we && bus.addr == PRIO_ADDR)
    begin
      prio_q <= (bus.wdata & `IPE_IP_USED) | `IPE_IP_FIXED;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      enable_q <= `IPE_EIE_RESET;
    end
    else if (bus.we && bus.addr == `IPE_EIE_ADDR)
    begin
      enable_q <= bus.wdata & `IPE_EIE_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_q <= 8'h00;
    end
    else if (bus.re)
    begin
      if (bus.addr == `IPE_EIE_ADDR)
      begin
        rdata_q <= enable_q & `IPE_EIE_USED;
      end
      else if (bus.addr == PRIO_ADDR)
      begin
        rdata_q <= prio_q | `IPE_IP_FIXED;
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign bus.prio_q = prio_q;
  assign bus.enable_q = enable_q;
  assign bus.rdata = rdata_q;
endmodule : ipe_sfr
`default_nettype wire

/* File: verilog/ipe_top.sv */
// Interrupt priority select and extended enable gating toward the core.
`timescale 1ns/10ps
`default_nettype none
`include "ipe_cfg.svh"
module ipe_top #(
  parameter logic [7:0] PRIO_ADDR = `IPE_IP_ADDR,
  parameter int PCA_FLAGS = `IPE_PCA_FLAGS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  input wire logic global_irq_gate,
  input wire logic [6:0] legacy_req,
  input wire logic [7:0] ext_prio,
  input wire logic timer3_low_overflow,
  input wire logic timer3_high_overflow,
  input wire logic comparator1_rise_flag,
  input wire logic comparator1_fall_flag,
  input wire logic comparator0_rise_flag,
  input wire logic comparator0_fall_flag,
  input wire logic [PCA_FLAGS-1:0] pca_req,
  input wire logic conversion_done_flag,
  input wire logic window_compare_flag,
  input wire logic smbus_req,
  input wire logic in_service_low,
  input wire logic in_service_high,
  output logic [13:0] src_pending,
  output logic [13:0] src_high_prio,
  output logic irq_high_req,
  output logic irq_low_req
);
  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  ipe_regs_if regs ();

  assign regs.addr = sfr_addr;
  assign regs.wdata = sfr_wdata;
  assign regs.we = sfr_we;
  assign regs.re = sfr_re;
  assign sfr_rdata = regs.rdata;

  ipe_sfr #(
    .PRIO_ADDR(PRIO_ADDR)
  ) u_sfr (
    .clock(clock),
    .srst(srst),
    .bus(regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source gating.
  function automatic logic gate_pair(input logic mask, input logic a, input logic b);
    gate_pair = mask & (a | b);
  endfunction : gate_pair

  logic timer3_irq_mask;
  logic comparator1_irq_mask;
  logic comparator0_irq_mask;
  logic counter_array_irq_mask;
  logic conversion_done_irq_mask;
  logic window_compare_irq_mask;
  logic smbus_irq_mask;
  logic serial_periph_prio;
  logic timer2_prio;
  logic uart_prio;
  logic timer1_prio;
  logic ext_input1_prio;
  logic timer0_prio;
  logic ext_input0_prio;
  ipe_pkg::ipe_src_vec_t src_req;
  ipe_pkg::ipe_src_vec_t src_prio;
  ipe_pkg::ipe_src_vec_t pending_d;
  ipe_pkg::ipe_src_vec_t pending_q;
  ipe_pkg::ipe_src_vec_t prio_q;
  logic high_any;
  logic low_any;
  logic irq_high_q;
  logic irq_low_q;

  assign timer3_irq_mask = regs.enable_q[`IPE_EIE_T3];
  assign comparator1_irq_mask = regs.enable_q[`IPE_EIE_CP1];
  assign comparator0_irq_mask = regs.enable_q[`IPE_EIE_CP0];
  assign counter_array_irq_mask = regs.enable_q[`IPE_EIE_PCA];
  assign conversion_done_irq_mask = regs.enable_q[`IPE_EIE_ADC];
  assign window_compare_irq_mask = regs.enable_q[`IPE_EIE_WIN];
  assign smbus_irq_mask = regs.enable_q[`IPE_EIE_SMB];
  assign serial_periph_prio = regs.prio_q[`IPE_IP_SPI];
  assign timer2_prio = regs.prio_q[`IPE_IP_T2];
  assign uart_prio = regs.prio_q[`IPE_IP_UART];
  assign timer1_prio = regs.prio_q[`IPE_IP_T1];
  assign ext_input1_prio = regs.prio_q[`IPE_IP_EXT1];
  assign timer0_prio = regs.prio_q[`IPE_IP_T0];
  assign ext_input0_prio = regs.prio_q[`IPE_IP_EXT0];

  // Sources in vector order: legacy seven, then extended ones.
  assign src_req[6:0] = legacy_req;
  assign src_req[7] = smbus_irq_mask & smbus_req;
  assign src_req[8] = window_compare_irq_mask & window_compare_flag;
  assign src_req[9] = conversion_done_irq_mask & conversion_done_flag;
  assign src_req[10] = counter_array_irq_mask & (|pca_req);
  assign src_req[11] = gate_pair(comparator0_irq_mask, comparator0_rise_flag,
                                 comparator0_fall_flag);
  assign src_req[12] = gate_pair(comparator1_irq_mask, comparator1_rise_flag,
                                 comparator1_fall_flag);
  assign src_req[13] = gate_pair(timer3_irq_mask, timer3_low_overflow,
                                 timer3_high_overflow);

  assign src_prio[0] = ext_input0_prio;
  assign src_prio[1] = timer0_prio;
  assign src_prio[2] = ext_input1_prio;
  assign src_prio[3] = timer1_prio;
  assign src_prio[4] = uart_prio;
  assign src_prio[5] = timer2_prio;
  assign src_prio[6] = serial_periph_prio;
  assign src_prio[7] = ext_prio[0];
  assign src_prio[8] = ext_prio[2];
  assign src_prio[9] = ext_prio[3];
  assign src_prio[10] = ext_prio[4];
  assign src_prio[11] = ext_prio[5];
  assign src_prio[12] = ext_prio[6];
  assign src_prio[13] = ext_prio[7];

  assign pending_d = src_req & {`IPE_NUM_SRC{global_irq_gate}};
  assign high_any = |(pending_d & src_prio);
  assign low_any = |(pending_d & ~src_prio);

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the core.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pending_q <= '0;
      prio_q <= '0;
    end
    else
    begin
      pending_q <= pending_d;
      prio_q <= src_prio;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
    end
    else
    begin
      irq_high_q <= high_any & ~in_service_high;
      irq_low_q <= low_any & ~in_service_high & ~in_service_low;
    end
  end

  assign src_pending = pending_q;
  assign src_high_prio = prio_q;
  assign irq_high_req = irq_high_q;
  assign irq_low_req = irq_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  serial_prio_a: assert property (@(posedge clock) disable iff (srst)
    sfr_we && sfr_addr == PRIO_ADDR |=> ##1 src_high_prio[6] == $past(sfr_wdata[6], 2))
    else $error("serial peripheral priority not taken from bit 6");
  timer2_prio_a: assert property (@(posedge clock) disable iff (srst)
    sfr_we && sfr_addr == PRIO_ADDR |=> ##1 src_high_prio[5] == $past(sfr_wdata[5], 2))
    else $error("timer 2 priority not taken from bit 5");
  timer1_prio_a: assert property (@(posedge clock) disable iff (srst)
    sfr_we && sfr_addr == PRIO_ADDR |=> ##1 src_high_prio[3] == $past(sfr_wdata[3], 2))
    else $error("timer 1 priority not taken from bit 3");
  low_prio_bits_a: assert property (@(posedge clock) disable iff (srst)
    ##1 {src_high_prio[4], src_high_prio[2:0]} ==
        {$past(regs.prio_q[4]), $past(regs.prio_q[2:0])})
    else $error("remaining priority bits mapped wrongly");
  prio_bit7_a: assert property (@(posedge clock) disable iff (srst)
    sfr_re && sfr_addr == PRIO_ADDR |=> sfr_rdata[7])
    else $error("priority bit 7 did not read one");
  enable_rw_a: assert property (@(posedge clock) disable iff (srst)
    sfr_we && sfr_addr == `IPE_EIE_ADDR ##1 sfr_re && sfr_addr == `IPE_EIE_ADDR && !sfr_we
    |=> sfr_rdata == ($past(sfr_wdata, 2) & `IPE_EIE_USED))
    else $error("extended enable read back differs from write");
  enable_reset_a: assert property (@(posedge clock)
    srst |=> regs.enable_q == `IPE_EIE_RESET && src_pending[13:7] == 7'h00)
    else $error("extended enable not cleared by reset");
  timer3_mask_a: assert property (@(posedge clock) disable iff (srst)
    global_irq_gate && timer3_irq_mask && timer3_high_overflow |=> src_pending[13])
    else $error("timer 3 request not passed");
  pca_mask_a: assert property (@(posedge clock) disable iff (srst)
    !counter_array_irq_mask |=> !src_pending[10])
    else $error("counter array request passed while masked");
  unused_bit1_a: assert property (@(posedge clock) disable iff (srst)
    sfr_re && sfr_addr == `IPE_EIE_ADDR |=> !sfr_rdata[1])
    else $error("extended enable bit 1 did not read zero");
  smbus_mask_a: assert property (@(posedge clock) disable iff (srst)
    src_pending[7] |-> $past(smbus_irq_mask) && $past(smbus_req))
    else $error("smbus request passed without its enable");
  global_gate_a: assert property (@(posedge clock) disable iff (srst)
    !global_irq_gate |=> src_pending == '0 && !irq_high_req && !irq_low_req)
    else $error("request reached core with global gate clear");
  preempt_a: assert property (@(posedge clock) disable iff (srst)
    in_service_low && !in_service_high && global_irq_gate && (|(src_req & src_prio))
    |=> irq_high_req && !irq_low_req)
    else $error("high request did not preempt low routine");
endmodule : ipe_top
`default_nettype wire

/* File: testbench/ipe_core_model.sv */
// Behavioural model of the core that takes and retires interrupt routines.
`timescale 1ns/10ps
`default_nettype none
module ipe_core_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic irq_high_req,
  input wire logic irq_low_req,
  input wire logic accept,
  input wire logic retire,
  output logic in_service_low,
  output logic in_service_high
);
  // A high request is taken before a low one when the core accepts.
  always_ff @(posedge clock)
  begin
    if (srst || retire)
    begin
      in_service_low <= 1'b0;
      in_service_high <= 1'b0;
    end
    else if (accept && irq_high_req)
    begin
      in_service_high <= 1'b1;
    end
    else if (accept && irq_low_req)
    begin
      in_service_low <= 1'b1;
    end
  end
endmodule : ipe_core_model
`default_nettype wire

/* File: testbench/tb_irq_priority_ext_enable.sv */
// Self-checking bench for the priority select and extended enable block.
`timescale 1ns/10ps
`default_nettype none
`include "ipe_cfg.svh"
module tb_irq_priority_ext_enable;
  localparam logic [7:0] PRIO = `IPE_IP_ADDR;
  localparam logic [7:0] EIE = `IPE_EIE_ADDR;
  localparam int PCA_N = 7;
  logic clock;
  logic srst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_we;
  logic sfr_re;
  logic [7:0] sfr_rdata;
  logic gate;
  logic [6:0] legacy_req;
  logic [7:0] ext_prio;
  logic [10:0] src_in;
  logic accept;
  logic retire;
  logic in_service_low;
  logic in_service_high;
  logic [13:0] src_pending;
  logic [13:0] src_high_prio;
  logic irq_high_req;
  logic irq_low_req;
  int errors = 0;
  int check_count = 0;
  int cycle_count = 0;
  int pend_bit[11] = '{7, 8, 9, 10, 10, 11, 11, 12, 12, 13, 13};
  int en_bit[11] = '{0, 2, 3, 4, 4, 5, 5, 6, 6, 7, 7};

  ipe_top #(.PRIO_ADDR(PRIO), .PCA_FLAGS(PCA_N)) ipe_top_i (
    .clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .global_irq_gate(gate),
    .legacy_req(legacy_req), .ext_prio(ext_prio), .timer3_low_overflow(src_in[9]),
    .timer3_high_overflow(src_in[10]), .comparator1_rise_flag(src_in[7]),
    .comparator1_fall_flag(src_in[8]), .comparator0_rise_flag(src_in[5]),
    .comparator0_fall_flag(src_in[6]),
    .pca_req({src_in[4], {(PCA_N - 2){1'b0}}, src_in[3]}),
    .conversion_done_flag(src_in[2]), .window_compare_flag(src_in[1]),
    .smbus_req(src_in[0]), .in_service_low(in_service_low),
    .in_service_high(in_service_high), .src_pending(src_pending),
    .src_high_prio(src_high_prio), .irq_high_req(irq_high_req), .irq_low_req(irq_low_req));

  ipe_core_model ipe_core_model_i (
    .clock(clock), .srst(srst), .irq_high_req(irq_high_req), .irq_low_req(irq_low_req),
    .accept(accept), .retire(retire), .in_service_low(in_service_low),
    .in_service_high(in_service_high));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(negedge clock);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(negedge clock);
    sfr_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge clock);
    sfr_re = 1'b0;
    @(negedge clock);
    chk(name, {6'h00, exp}, {6'h00, sfr_rdata});
  endtask : rd

  task automatic pulse(input logic hi_not_lo);
    accept = hi_not_lo;
    retire = !hi_not_lo;
    @(negedge clock);
    accept = 1'b0;
    retire = 1'b0;
    settle();
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(EIE, 8'h00, "enable reset");
    rd(PRIO, 8'h80, "priority reset");
  endtask : t_reset

  task automatic t_prio;
    wr(PRIO, 8'h7F);
    rd(PRIO, 8'hFF, "priority all");
    wr(PRIO, 8'h00);
    rd(PRIO, 8'h80, "priority bit7");
    for (int i = 0; i < 7; i++)
    begin
      wr(PRIO, 8'h01 << i);
      settle();
      chk("priority map", 14'h0001 << i, src_high_prio & 14'h007F);
    end
    ext_prio = 8'hA6;
    settle();
    chk("ext priority", {ext_prio[7:2], ext_prio[0], 7'h40}, src_high_prio);
    ext_prio = 8'h00;
    wr(PRIO, 8'h00);
    settle();
  endtask : t_prio

  task automatic t_enable_reg;
    wr(EIE, 8'hFF);
    rd(EIE, 8'hFD, "enable all");
    rd(8'h55, 8'h00, "unmapped read");
    wr(EIE, 8'h00);
    rd(EIE, 8'h00, "enable clear");
  endtask : t_enable_reg

  task automatic t_gating;
    gate = 1'b1;
    for (int j = 0; j < 11; j++)
    begin
      wr(EIE, 8'h01 << en_bit[j]);
      src_in = 11'h001 << j;
      settle();
      chk("source passed", 14'h0001 << pend_bit[j], src_pending);
      wr(EIE, ~(8'h01 << en_bit[j]));
      settle();
      chk("source masked", 14'h0000, src_pending);
    end
    src_in = 11'h000;
  endtask : t_gating

  task automatic t_global;
    wr(EIE, 8'hFF);
    src_in = 11'h7FF;
    legacy_req = 7'h7F;
    gate = 1'b0;
    settle();
    chk("gated pending", 14'h0000, src_pending);
    chk("gated irq", 14'h0000, {12'h000, irq_high_req, irq_low_req});
    gate = 1'b1;
    settle();
    chk("open pending", 14'h3FFF, src_pending);
    src_in = 11'h000;
    legacy_req = 7'h00;
    wr(EIE, 8'h00);
    settle();
  endtask : t_global

  task automatic t_preempt;
    wr(PRIO, 8'h01);
    legacy_req = 7'h02;
    settle();
    chk("low request", 14'h0001, {11'h000, in_service_low, irq_high_req, irq_low_req});
    pulse(1'b1);
    chk("low served", 14'h0004, {11'h000, in_service_low, irq_high_req, irq_low_req});
    legacy_req = 7'h03;
    settle();
    chk("high preempt", 14'h0006, {11'h000, in_service_low, irq_high_req, irq_low_req});
    pulse(1'b1);
    chk("high served", 14'h0004, {11'h000, in_service_high, irq_high_req, irq_low_req});
    legacy_req = 7'h00;
    pulse(1'b0);
  endtask : t_preempt

  task automatic t_midreset;
    wr(EIE, 8'hFD);
    src_in = 11'h7FF;
    settle();
    chk("pending before reset", 14'h3F80, src_pending);
    wr(PRIO, 8'h7F);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    rd(EIE, 8'h00, "enable midrun reset");
    rd(PRIO, 8'h80, "priority midrun reset");
    chk("pending midrun reset", 14'h0000, src_pending);
    chk("prio midrun reset", 14'h0000, src_high_prio);
    src_in = 11'h000;
  endtask : t_midreset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cuts a hang short well beyond the roughly 150 cycles the tests need.
  always @(posedge clock)
  begin
    cycle_count++;
    if (cycle_count == 3000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    srst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    sfr_re = 1'b0;
    gate = 1'b0;
    legacy_req = 7'h00;
    ext_prio = 8'h00;
    src_in = 11'h000;
    accept = 1'b0;
    retire = 1'b0;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_prio();
    t_enable_reg();
    t_gating();
    t_global();
    t_preempt();
    t_midreset();
    test_done();
  end
endmodule : tb_irq_priority_ext_enable
`default_nettype wire
